/* File: verilog/capture_compare_value_regs.sv */
// capture/compare value registers of a two-channel timer
// How it works
// - preload off: channel one write reaches active compare at once
// - preload on: channel one active loads from preload on update
// - channel one active compared with counter drives output reference
// - input mode: channel one holds last captured counter, writes ignored
// - channel two: immediate or update-timed load per preload enable
// - channel two active compared with counter drives output reference
// - input mode: channel two holds last captured counter, writes ignored
// - values reset to zero, at offsets 0x34 and 0x38
// - 16-bit registers; reserved addresses hold nothing and read zero
// - direction select zero means output, nonzero means capture input
// - capture enable clear blocks every capture
// - update disable blocks update events; preloaded active values hold, while with preload off a write still reaches active
`timescale 1ns/1ps
`default_nettype none
`include "cc_consts.svh"
module capture_compare_value_regs
  import cc_pkg::*;
(
  input  wire logic               ref_clk,                // kernel clock
  input  wire logic               rst_n,                  // async reset
  input  wire logic [`ADDR_W-1:0] reg_addr,               // byte address
  input  wire logic [`DATA_W-1:0] reg_wdata,              // write data
  input  wire logic               reg_write,              // write strobe
  input  wire logic               reg_read,               // read strobe
  output logic      [`DATA_W-1:0] reg_rdata,              // read data +1
  input  wire logic [`DATA_W-1:0] timer_counter,          // counter value
  input  wire logic               update_request,         // raw update pulse
  input  wire logic               chan_one_capture_event, // capture pulse
  input  wire logic               chan_two_capture_event, // capture pulse
  output logic                    chan_one_output,        // match reference
  output logic                    chan_two_output         // match reference
);

  ctrl_t       ctrl;
  chan_state_t chan_one;
  chan_state_t chan_two;
  status_t     status;
  logic        update_event;
  logic        chan_one_write;
  logic        chan_two_write;
  logic        ctrl_write;

  assign update_event   = update_request && !ctrl.update_disable;
  assign chan_one_write = reg_write && (reg_addr == `CHAN_ONE_VALUE_OFS);
  assign chan_two_write = reg_write && (reg_addr == `CHAN_TWO_VALUE_OFS);
  assign ctrl_write     = reg_write && (reg_addr == `CTRL_OFS);

  cc_config u_config (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_en   (ctrl_write),
    .wdata   (reg_wdata),
    .ctrl    (ctrl)
  );

  cc_channel u_chan_one (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .cfg           (ctrl.chan_one),
    .value_write   (chan_one_write),
    .wdata         (reg_wdata),
    .update_event  (update_event),
    .capture_event (chan_one_capture_event),
    .timer_counter (timer_counter),
    .state         (chan_one)
  );

  cc_channel u_chan_two (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .cfg           (ctrl.chan_two),
    .value_write   (chan_two_write),
    .wdata         (reg_wdata),
    .update_event  (update_event),
    .capture_event (chan_two_capture_event),
    .timer_counter (timer_counter),
    .state         (chan_two)
  );

  assign chan_one_output = chan_one.output_ref;
  assign chan_two_output = chan_two.output_ref;

  always_comb begin
    status                 = '0;
    status.chan_one_input  = mode_of(ctrl.chan_one.direction_select)
                             == MODE_INPUT;
    status.chan_two_input  = mode_of(ctrl.chan_two.direction_select)
                             == MODE_INPUT;
    status.chan_one_output = chan_one.output_ref;
    status.chan_two_output = chan_two.output_ref;
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `READ_IDLE;
    end else if (!reg_read) begin
      reg_rdata <= `READ_IDLE;
    end else if (reg_addr == `CHAN_ONE_VALUE_OFS) begin
      reg_rdata <= chan_one.value;
    end else if (reg_addr == `CHAN_TWO_VALUE_OFS) begin
      reg_rdata <= chan_two.value;
    end else if (reg_addr == `CTRL_OFS) begin
      reg_rdata <= {{`CTRL_PAD_W{1'b0}}, ctrl};
    end else if (reg_addr == `STATUS_OFS) begin
      reg_rdata <= status;
    end else if (reg_addr == `CHAN_ONE_ACTIVE_OFS) begin
      reg_rdata <= chan_one.active;
    end else if (reg_addr == `CHAN_TWO_ACTIVE_OFS) begin
      reg_rdata <= chan_two.active;
    end else begin
      reg_rdata <= `READ_IDLE;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/cc_consts.svh */
// constants for the capture/compare value register block
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH
`define ADDR_W              8
`define DATA_W              16
`define CHAN_ONE_VALUE_OFS  8'h34
`define CHAN_TWO_VALUE_OFS  8'h38
`define CTRL_OFS            8'h50
`define STATUS_OFS          8'h54
`define CHAN_ONE_ACTIVE_OFS 8'h58
`define CHAN_TWO_ACTIVE_OFS 8'h5C
`define VALUE_RESET         16'h0000
`define CTRL_RESET          9'h000
`define READ_IDLE           16'h0000
`define DIR_OUTPUT          2'h0
`define STATUS_RSVD_W       12
`define CTRL_PAD_W          7
`endif

/* File: verilog/cc_pkg.sv */
// types shared by the capture/compare value register block
`include "cc_consts.svh"
package cc_pkg;

  typedef struct packed {
    logic       capture_enable;
    logic       preload_enable;
    logic [1:0] direction_select;
  } chan_cfg_t;

  typedef struct packed {
    logic      update_disable;
    chan_cfg_t chan_two;
    chan_cfg_t chan_one;
  } ctrl_t;

  typedef struct packed {
    logic [`DATA_W-1:0] value;
    logic [`DATA_W-1:0] active;
    logic               output_ref;
  } chan_state_t;

  typedef struct packed {
    logic [`STATUS_RSVD_W-1:0] reserved;
    logic                      chan_two_output;
    logic                      chan_one_output;
    logic                      chan_two_input;
    logic                      chan_one_input;
  } status_t;

  typedef enum logic [1:0] {
    MODE_OUTPUT = 2'h1,
    MODE_INPUT  = 2'h2
  } chan_mode_t;

  function automatic chan_mode_t mode_of(input logic [1:0] dir);
    if (dir == `DIR_OUTPUT) begin
      return MODE_OUTPUT;
    end
    return MODE_INPUT;
  endfunction

endpackage

/* File: verilog/cc_config.sv */
// configuration register: direction, preload, capture enable, update disable
`timescale 1ns/1ps
`default_nettype none
`include "cc_consts.svh"
module cc_config
  import cc_pkg::*;
(
  input  wire logic               ref_clk,  // kernel clock
  input  wire logic               rst_n,    // async reset, active low
  input  wire logic               wr_en,    // write strobe for this register
  input  wire logic [`DATA_W-1:0] wdata,    // write data
  output var ctrl_t               ctrl      // stored configuration
);

  ctrl_t next_ctrl;

  always_comb begin
    next_ctrl = ctrl_t'(wdata[$bits(ctrl_t)-1:0]);
    // direction only changes while the channel is off
    if (ctrl.chan_one.capture_enable) begin
      next_ctrl.chan_one.direction_select = ctrl.chan_one.direction_select;
    end
    if (ctrl.chan_two.capture_enable) begin
      next_ctrl.chan_two.direction_select = ctrl.chan_two.direction_select;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= ctrl_t'(`CTRL_RESET);
    end else if (wr_en) begin
      ctrl <= next_ctrl;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/cc_channel.sv */
// one capture/compare channel: preload, active compare, capture, match
`timescale 1ns/1ps
`default_nettype none
`include "cc_consts.svh"
module cc_channel
  import cc_pkg::*;
(
  input  wire logic               ref_clk,       // kernel clock
  input  wire logic               rst_n,         // async reset, active low
  input  wire chan_cfg_t          cfg,           // channel configuration
  input  wire logic               value_write,   // software write to value
  input  wire logic [`DATA_W-1:0] wdata,         // write data
  input  wire logic               update_event,  // gated update event
  input  wire logic               capture_event, // filtered capture pulse
  input  wire logic [`DATA_W-1:0] timer_counter, // counter value
  output var chan_state_t         state          // value, active, match
);

  chan_mode_t         mode;
  logic [`DATA_W-1:0] value;
  logic [`DATA_W-1:0] active;
  logic               output_ref;

  assign mode  = mode_of(cfg.direction_select);
  // one driver per field, gathered into the carrier here
  assign state = {value, active, output_ref};

  // preload in output mode, captured counter in input mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= `VALUE_RESET;
    end else if (mode == MODE_INPUT) begin
      if (capture_event && cfg.capture_enable) begin
        value <= timer_counter;
      end
    end else if (value_write) begin
      value <= wdata;
    end
  end

  // active compare register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= `VALUE_RESET;
    end else if (mode == MODE_OUTPUT) begin
      if (value_write && !cfg.preload_enable) begin
        active <= wdata;
      end else if (update_event && cfg.preload_enable) begin
        active <= value;
      end
    end
  end

  // registered match of counter against active value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_ref <= 1'b0;
    end else begin
      output_ref <= (mode == MODE_OUTPUT) &&
                    (timer_counter == active);
    end
  end

endmodule
`default_nettype wire

/* File: sim/capture_compare_value_regs_sva.sv */
// assertion checker for the capture/compare value registers
`timescale 1ns/1ps
`default_nettype none
module capture_compare_value_regs_sva (
  input wire logic        ref_clk,                // clock
  input wire logic        rst_n,                  // reset
  input wire logic [7:0]  reg_addr,               // address
  input wire logic [15:0] reg_wdata,              // write data
  input wire logic        reg_write,              // write strobe
  input wire logic        reg_read,               // read strobe
  input wire logic [15:0] reg_rdata,              // read data
  input wire logic [15:0] timer_counter,          // counter
  input wire logic        update_request,         // update pulse
  input wire logic        chan_one_capture_event, // capture one
  input wire logic        chan_two_capture_event, // capture two
  input wire logic        chan_one_output,        // match one
  input wire logic        chan_two_output         // match two
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_unmapped_read: assert property (
    reg_read && reg_addr == 8'h3C |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_status_resv: assert property (
    reg_read && reg_addr == 8'h54 |=> reg_rdata[15:4] == 12'h000)
    else $error("status spare bits set");
  a_reset_clear: assert property (
    $rose(rst_n) |-> !chan_one_output && !chan_two_output)
    else $error("outputs set after reset");
  a_hold_one: assert property (
    chan_one_output && $past(chan_one_output) &&
    !$past(reg_write, 2) && !$past(update_request, 2)
    |-> $past(timer_counter) == $past(timer_counter, 2))
    else $error("channel one match moved");
  a_hold_two: assert property (
    chan_two_output && $past(chan_two_output) &&
    !$past(reg_write, 2) && !$past(update_request, 2)
    |-> $past(timer_counter) == $past(timer_counter, 2))
    else $error("channel two match moved");
  a_active_one: assert property (
    $past(reg_read && reg_addr == 8'h58) && chan_one_output
    |-> reg_rdata == $past(timer_counter))
    else $error("channel one match wrong");
  a_active_two: assert property (
    $past(reg_read && reg_addr == 8'h5C) && chan_two_output
    |-> reg_rdata == $past(timer_counter))
    else $error("channel two match wrong");
endmodule
bind capture_compare_value_regs capture_compare_value_regs_sva i_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .timer_counter(timer_counter),
  .update_request(update_request),
  .chan_one_capture_event(chan_one_capture_event),
  .chan_two_capture_event(chan_two_capture_event),
  .chan_one_output(chan_one_output), .chan_two_output(chan_two_output));
`default_nettype wire

/* File: sim/tb_capture_compare_value_regs.sv */
// self-checking bench for the capture/compare value registers
`timescale 1ns/1ps
`default_nettype none
module tb_capture_compare_value_regs;
  logic        ref_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0;
  logic        reg_read = 1'b0, update_request = 1'b0, out_one, out_two;
  logic        cap_one = 1'b0, cap_two = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, timer_counter = 16'h0000;
  logic [15:0] reg_rdata, c, dv [2];
  logic [31:0] seed = 32'h2C5A1EFB;
  int          n_fail = 0, tests_run = 0, cycles = 0;
  capture_compare_value_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_counter(timer_counter), .update_request(update_request),
    .chan_one_capture_event(cap_one), .chan_two_capture_event(cap_two),
    .chan_one_output(out_one), .chan_two_output(out_two));
  initial forever #12.5 ref_clk = ~ref_clk;
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [15:0] ctrl_word(input int k);
    return 16'(8'h88 | k | (k << 4));
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic capture(input int ch, input logic [15:0] v);
    @(posedge ref_clk);
    timer_counter <= v;
    {cap_two, cap_one} <= (ch == 1) ? 2'h2 : 2'h1;
    @(posedge ref_clk);
    timer_counter <= ~v;
    {cap_two, cap_one} <= 2'h0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h34, 16'h0000);
    rd(8'h38, 16'h0000);
    rd(8'h54, 16'h000C);
    wr(8'h3C, 16'hFFFF);
    rd(8'h3C, 16'h0000);
    $display("reset and map test done");
    for (int ch = 0; ch < 2; ch++) begin
      dv[ch] = rnd();
      wr(8'h34 + 8'(4 * ch), dv[ch]);
      rd(8'h34 + 8'(4 * ch), dv[ch]);
      @(posedge ref_clk);
      timer_counter <= dv[ch];
      rd(8'h58 + 8'(4 * ch), dv[ch]);
      check({15'h0000, ch ? out_two : out_one}, 16'h0001);
      @(posedge ref_clk);
      timer_counter <= dv[ch] + 16'h0001;
      repeat (2) @(posedge ref_clk);
      #1 check({15'h0000, ch ? out_two : out_one}, 16'h0000);
    end
    $display("direct load and match test done");
    wr(8'h50, 16'h0044);
    for (int ch = 0; ch < 2; ch++) begin
      c = rnd();
      wr(8'h34 + 8'(4 * ch), c);
      rd(8'h58 + 8'(4 * ch), dv[ch]);
      @(posedge ref_clk);
      update_request <= 1'b1;
      @(posedge ref_clk);
      update_request <= 1'b0;
      rd(8'h58 + 8'(4 * ch), c);
    end
    wr(8'h50, 16'h0144);
    wr(8'h38, ~c);
    update_request <= 1'b1;
    @(posedge ref_clk);
    update_request <= 1'b0;
    rd(8'h5C, c);
    rd(8'h38, ~c);
    $display("preload and update test done");
    for (int k = 1; k < 4; k++) begin
      wr(8'h50, 16'h0000);
      wr(8'h50, ctrl_word(k));
      rd(8'h50, ctrl_word(k));
      rd(8'h54, 16'h0003);
      for (int ch = 0; ch < 2; ch++) begin
        c = rnd();
        capture(ch, c);
        wr(8'h34 + 8'(4 * ch), ~c);
        rd(8'h34 + 8'(4 * ch), c);
      end
    end
    wr(8'h50, 16'h0033);
    capture(1, ~c);
    rd(8'h38, c);
    $display("capture test done");
    final_report();
  end
endmodule
`default_nettype wire
